// [hdl/lsir_regs.sv]
// line status and interrupt register group behind an axi4-lite slave
`timescale 1ns/100ps
module lsir_regs
    import lsir_pkg::*;
#(
    parameter int SECOND_CYCLES = LSIR_SECOND_CYCLES,
    parameter int SPACING_W = 7,
    parameter int GAIN_W = 5
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // line side
    input wire logic driver_fail_pin,
    input wire logic signal_loss_pin,
    input wire logic [GAIN_W-1:0] equalizer_gain_in,
    input wire logic [SPACING_W-1:0] tx_pointer_spacing,
    input wire logic [SPACING_W-1:0] rx_pointer_spacing,
    input wire logic [15:0] excess_zero_count,
    input wire lsir_events_t line_events,
    output lsir_term_t tx_term,
    output lsir_term_t rx_term,
    output logic tx_peak_measure_select,
    output logic rx_peak_measure_select,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // registers and state

    logic [7:0] termination_select;
    logic [7:0] line_interrupt_enable_a;
    logic [7:0] line_interrupt_enable_b;
    logic [7:0] interrupt_edge_select;
    logic [7:0] line_interrupt_pending_a;
    logic [7:0] line_interrupt_pending_b;
    logic [7:0] counter_control;
    logic [7:0] tx_test_reg;
    logic [7:0] rx_test_reg;
    logic [15:0] counter_snapshot;
    logic [SPACING_W-1:0] tx_jitter_measure;
    logic [SPACING_W-1:0] rx_jitter_measure;
    logic [SPACING_W-1:0] tx_min;
    logic [SPACING_W-1:0] tx_max;
    logic [SPACING_W-1:0] rx_min;
    logic [SPACING_W-1:0] rx_max;
    logic strobe_prev;
    logic [31:0] second_count;
    logic driver_fail_meta;
    logic driver_fail_live;
    logic signal_loss_meta;
    logic signal_loss_live;
    logic driver_fail_prev;
    logic signal_loss_prev;

    lsir_wstate_t wstate;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;

    logic wr_fire;
    logic [7:0] wr_idx;
    logic rd_fire;
    logic [7:0] rd_idx;
    logic [7:0] rd_value;
    logic rd_hit;
    logic wr_hit;
    logic second_tick;
    logic counter_report_mode;
    logic counter_snapshot_strobe;
    logic driver_fail_event;
    logic signal_loss_event;
    logic [7:0] next_pending_a;
    logic [7:0] next_pending_b;
    logic [7:0] events_b;
    logic tx_jit_clear;
    logic rx_jit_clear;
    logic tx_jit_read;
    logic rx_jit_read;

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel: address and data taken in either order

    assign s_axi_awready = (wstate == LSIR_W_IDLE) && !aw_held;
    assign s_axi_wready = (wstate == LSIR_W_IDLE) && !w_held;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wstate <= LSIR_W_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end
        else if (ce)
        begin
            case (wstate)
                LSIR_W_IDLE:
                begin
                    if (s_axi_awvalid && s_axi_awready)
                    begin
                        aw_held <= 1'b1;
                        aw_addr <= s_axi_awaddr;
                    end
                    if (s_axi_wvalid && s_axi_wready)
                    begin
                        w_held <= 1'b1;
                        w_data <= s_axi_wdata[7:0];
                        w_lane0 <= s_axi_wstrb[0];
                    end
                    if (wr_fire)
                    begin
                        wstate <= LSIR_W_RESP;
                        aw_held <= 1'b0;
                        w_held <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
                    end
                end
                LSIR_W_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        s_axi_bvalid <= 1'b0;
                        wstate <= LSIR_W_IDLE;
                    end
                end
                default:
                    wstate <= LSIR_W_IDLE;
            endcase
        end
    end

    // a write is performed in the same cycle that both halves are held
    assign wr_fire = (wstate == LSIR_W_IDLE) && aw_held && w_held;
    assign wr_idx = {2'b00, aw_addr[7:2]};

    always_comb
    begin
        case (wr_idx)
            LSIR_IDX_TX_TEST, LSIR_IDX_RX_TEST, LSIR_IDX_CNT_CTRL, LSIR_IDX_TERM,
            LSIR_IDX_EN_A, LSIR_IDX_EN_B, LSIR_IDX_EDGE, LSIR_IDX_LIVE, LSIR_IDX_GAIN,
            LSIR_IDX_TX_JIT, LSIR_IDX_RX_JIT, LSIR_IDX_PEND_A, LSIR_IDX_PEND_B,
            LSIR_IDX_CNT_HI, LSIR_IDX_CNT_LO:
                wr_hit = 1'b1;
            default:
                wr_hit = 1'b0;
        endcase
    end

    // write effects only when byte lane 0 is strobed
    function automatic logic wr_to(input logic [7:0] idx);
        wr_to = wr_fire && w_lane0 && (wr_idx == idx);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel: one cycle from address to data

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_idx = {2'b00, s_axi_araddr[7:2]};

    always_comb
    begin
        rd_hit = 1'b1;
        case (rd_idx)
            LSIR_IDX_TX_TEST: rd_value = tx_test_reg;
            LSIR_IDX_RX_TEST: rd_value = rx_test_reg;
            LSIR_IDX_CNT_CTRL: rd_value = counter_control;
            LSIR_IDX_TERM: rd_value = termination_select;
            LSIR_IDX_EN_A: rd_value = line_interrupt_enable_a;
            LSIR_IDX_EN_B: rd_value = line_interrupt_enable_b;
            LSIR_IDX_EDGE: rd_value = interrupt_edge_select;
            // live status bits
            LSIR_IDX_LIVE: rd_value = {5'b00000, driver_fail_live, 1'b0, signal_loss_live};
            LSIR_IDX_GAIN: rd_value = 8'(equalizer_gain_in);
            LSIR_IDX_TX_JIT: rd_value = 8'(tx_jitter_measure);
            LSIR_IDX_RX_JIT: rd_value = 8'(rx_jitter_measure);
            LSIR_IDX_PEND_A: rd_value = line_interrupt_pending_a;
            LSIR_IDX_PEND_B: rd_value = line_interrupt_pending_b;
            LSIR_IDX_CNT_HI: rd_value = counter_snapshot[15:8];
            LSIR_IDX_CNT_LO: rd_value = counter_snapshot[7:0];
            default:
            begin
                rd_value = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end
        else if (ce)
        begin
            if (rd_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_value};
                s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // plain control registers, reserved bits masked off

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            termination_select <= LSIR_RST_TERM;
            line_interrupt_enable_a <= LSIR_RST_ZERO;
            line_interrupt_enable_b <= LSIR_RST_ZERO;
            interrupt_edge_select <= LSIR_RST_ZERO;
            counter_control <= LSIR_RST_ZERO;
            tx_test_reg <= LSIR_RST_ZERO;
            rx_test_reg <= LSIR_RST_ZERO;
        end
        else if (ce)
        begin
            if (wr_to(LSIR_IDX_TERM))
                termination_select <= w_data & LSIR_MASK_TERM;
            if (wr_to(LSIR_IDX_EN_A))
                line_interrupt_enable_a <= w_data & LSIR_MASK_A;
            if (wr_to(LSIR_IDX_EN_B))
                line_interrupt_enable_b <= w_data & LSIR_MASK_B;
            if (wr_to(LSIR_IDX_EDGE))
                interrupt_edge_select <= w_data & LSIR_MASK_A;
            if (wr_to(LSIR_IDX_CNT_CTRL))
                counter_control <= w_data & LSIR_MASK_CNT_CTRL;
            if (wr_to(LSIR_IDX_TX_TEST))
                tx_test_reg <= w_data & LSIR_MASK_TEST;
            if (wr_to(LSIR_IDX_RX_TEST))
                rx_test_reg <= w_data & LSIR_MASK_TEST;
        end
    end

    assign tx_peak_measure_select = tx_test_reg[LSIR_BIT_PEAK];
    assign rx_peak_measure_select = rx_test_reg[LSIR_BIT_PEAK];

    ////////////////////////////////////////////////////////////////////////////
    // termination decode

    function automatic lsir_term_t term_decode(input logic [2:0] sel);
        term_decode = '0;
        if (sel[2])
            term_decode.bypass = 1'b1;
        else
        begin
            case (sel[1:0])
                2'b00: term_decode.ohm_75 = 1'b1;
                2'b01: term_decode.ohm_120 = 1'b1;
                2'b10: term_decode.ohm_100 = 1'b1;
                default: term_decode.ohm_110 = 1'b1;
            endcase
        end
    endfunction

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tx_term <= term_decode(3'b000);
            rx_term <= term_decode(3'b111);
        end
        else if (ce)
        begin
            tx_term <= term_decode(termination_select[LSIR_TX_TERM_LSB +: 3]);
            rx_term <= term_decode(termination_select[2:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // excess-zero counter snapshot

    assign counter_report_mode = counter_control[LSIR_BIT_MODE];
    assign counter_snapshot_strobe = counter_control[LSIR_BIT_STROBE];
    assign second_tick = (second_count == 32'(SECOND_CYCLES - 1));

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            strobe_prev <= 1'b0;
            second_count <= 32'h00000000;
            counter_snapshot <= 16'h0000;
        end
        else if (ce)
        begin
            // only a fresh zero-to-one edge counts, so a held one is ignored
            strobe_prev <= counter_snapshot_strobe;
            second_count <= second_tick ? 32'h00000000 : second_count + 32'h00000001;
            if (!counter_report_mode && counter_snapshot_strobe && !strobe_prev)
                counter_snapshot <= excess_zero_count;
            else if (counter_report_mode && second_tick)
                counter_snapshot <= excess_zero_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // live status synchronisers and change detection

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            driver_fail_meta <= 1'b0;
            driver_fail_live <= 1'b0;
            signal_loss_meta <= 1'b0;
            signal_loss_live <= 1'b0;
            driver_fail_prev <= 1'b0;
            signal_loss_prev <= 1'b0;
        end
        else if (ce)
        begin
            driver_fail_meta <= driver_fail_pin;
            driver_fail_live <= driver_fail_meta;
            signal_loss_meta <= signal_loss_pin;
            signal_loss_live <= signal_loss_meta;
            driver_fail_prev <= driver_fail_live;
            signal_loss_prev <= signal_loss_live;
        end
    end

    // edge select zero: rising only one: either direction
    assign driver_fail_event = interrupt_edge_select[LSIR_BIT_DF]
        ? (driver_fail_live ^ driver_fail_prev) : (driver_fail_live & !driver_fail_prev);
    assign signal_loss_event = interrupt_edge_select[LSIR_BIT_LOS]
        ? (signal_loss_live ^ signal_loss_prev) : (signal_loss_live & !signal_loss_prev);

    ////////////////////////////////////////////////////////////////////////////
    // pending flags: write one clears, a new event in the same cycle wins

    assign events_b = {1'b0, line_events.pulse_sum_overflow, line_events.tx_fifo_slip,
                       line_events.rx_fifo_slip, 1'b0, line_events.excess_zero,
                       line_events.code_violation, line_events.counter_overflow};

    always_comb
    begin
        next_pending_a = line_interrupt_pending_a;
        next_pending_b = line_interrupt_pending_b;
        if (wr_to(LSIR_IDX_PEND_A))
            next_pending_a = next_pending_a & ~w_data;
        if (wr_to(LSIR_IDX_PEND_B))
            next_pending_b = next_pending_b & ~w_data;
        next_pending_a[LSIR_BIT_DF] = next_pending_a[LSIR_BIT_DF] | driver_fail_event;
        next_pending_a[LSIR_BIT_LOS] = next_pending_a[LSIR_BIT_LOS] | signal_loss_event;
        next_pending_b = (next_pending_b | events_b) & LSIR_MASK_B;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            line_interrupt_pending_a <= LSIR_RST_ZERO;
            line_interrupt_pending_b <= LSIR_RST_ZERO;
        end
        else if (ce)
        begin
            line_interrupt_pending_a <= next_pending_a & LSIR_MASK_A;
            line_interrupt_pending_b <= next_pending_b;
        end
    end

    // level interrupt from enabled pending flags
    always_ff @(posedge clock)
    begin
        if (rst)
            irq <= 1'b0;
        else if (ce)
            irq <= |(next_pending_a & line_interrupt_enable_a)
                | |(next_pending_b & line_interrupt_enable_b);
    end

    ////////////////////////////////////////////////////////////////////////////
    // jitter measures; a read restarts the peak window

    assign tx_jit_clear = wr_to(LSIR_IDX_TX_JIT) && w_data[0];
    assign rx_jit_clear = wr_to(LSIR_IDX_RX_JIT) && w_data[0];
    assign tx_jit_read = rd_fire && (rd_idx == LSIR_IDX_TX_JIT);
    assign rx_jit_read = rd_fire && (rd_idx == LSIR_IDX_RX_JIT);

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tx_min <= '0;
            tx_max <= '0;
            tx_jitter_measure <= '0;
        end
        else if (ce)
        begin
            if (tx_jit_read || tx_jit_clear)
            begin
                tx_min <= tx_pointer_spacing;
                tx_max <= tx_pointer_spacing;
            end
            else
            begin
                if (tx_pointer_spacing < tx_min)
                    tx_min <= tx_pointer_spacing;
                if (tx_pointer_spacing > tx_max)
                    tx_max <= tx_pointer_spacing;
            end
            if (tx_jit_clear)
                tx_jitter_measure <= '0;
            else if (tx_peak_measure_select)
                tx_jitter_measure <= tx_max - tx_min;
            else
                tx_jitter_measure <= tx_pointer_spacing;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rx_min <= '0;
            rx_max <= '0;
            rx_jitter_measure <= '0;
        end
        else if (ce)
        begin
            if (rx_jit_read || rx_jit_clear)
            begin
                rx_min <= rx_pointer_spacing;
                rx_max <= rx_pointer_spacing;
            end
            else
            begin
                if (rx_pointer_spacing < rx_min)
                    rx_min <= rx_pointer_spacing;
                if (rx_pointer_spacing > rx_max)
                    rx_max <= rx_pointer_spacing;
            end
            if (rx_jit_clear)
                rx_jitter_measure <= '0;
            else if (rx_peak_measure_select)
                rx_jitter_measure <= rx_max - rx_min;
            else
                rx_jitter_measure <= rx_pointer_spacing;
        end
    end

endmodule

// [hdl/lsir_pkg.sv]
// constants and carrier types for the line status and interrupt register group
package lsir_pkg;
    // register indexes; byte address is four times the index
    localparam logic [7:0] LSIR_IDX_TX_TEST = 8'h21;
    localparam logic [7:0] LSIR_IDX_RX_TEST = 8'h27;
    localparam logic [7:0] LSIR_IDX_CNT_CTRL = 8'h31;
    localparam logic [7:0] LSIR_IDX_TERM = 8'h32;
    localparam logic [7:0] LSIR_IDX_EN_A = 8'h33;
    localparam logic [7:0] LSIR_IDX_EN_B = 8'h34;
    localparam logic [7:0] LSIR_IDX_EDGE = 8'h35;
    localparam logic [7:0] LSIR_IDX_LIVE = 8'h36;
    localparam logic [7:0] LSIR_IDX_GAIN = 8'h37;
    localparam logic [7:0] LSIR_IDX_TX_JIT = 8'h38;
    localparam logic [7:0] LSIR_IDX_RX_JIT = 8'h39;
    localparam logic [7:0] LSIR_IDX_PEND_A = 8'h3A;
    localparam logic [7:0] LSIR_IDX_PEND_B = 8'h3B;
    localparam logic [7:0] LSIR_IDX_CNT_HI = 8'h3C;
    localparam logic [7:0] LSIR_IDX_CNT_LO = 8'h3D;

    // writable bit masks; all other bits are reserved
    localparam logic [7:0] LSIR_MASK_TEST = 8'h20;
    localparam logic [7:0] LSIR_MASK_CNT_CTRL = 8'h03;
    localparam logic [7:0] LSIR_MASK_TERM = 8'h3F;
    localparam logic [7:0] LSIR_MASK_A = 8'h05;
    localparam logic [7:0] LSIR_MASK_B = 8'h77;

    // field positions
    localparam int LSIR_BIT_STROBE = 0;
    localparam int LSIR_BIT_MODE = 1;
    localparam int LSIR_BIT_DF = 2;
    localparam int LSIR_BIT_LOS = 0;
    localparam int LSIR_BIT_PEAK = 5;
    localparam int LSIR_TX_TERM_LSB = 3;

    // reset values
    localparam logic [7:0] LSIR_RST_TERM = 8'h07;
    localparam logic [7:0] LSIR_RST_ZERO = 8'h00;

    // one second at the core clock rate
    localparam int LSIR_CLOCK_HZ = 25000000;
    localparam int LSIR_SECOND_S = 1;
    localparam int LSIR_SECOND_CYCLES = LSIR_SECOND_S * LSIR_CLOCK_HZ;

    // termination decode, one bit per matching choice
    typedef struct packed {
        logic bypass;
        logic ohm_110;
        logic ohm_100;
        logic ohm_120;
        logic ohm_75;
    } lsir_term_t;

    // same-clock event pulses from the line logic
    typedef struct packed {
        logic pulse_sum_overflow;
        logic tx_fifo_slip;
        logic rx_fifo_slip;
        logic excess_zero;
        logic code_violation;
        logic counter_overflow;
    } lsir_events_t;

    typedef enum logic [1:0] {
        LSIR_W_IDLE = 2'b00,
        LSIR_W_RESP = 2'b01
    } lsir_wstate_t;
endpackage

// [verification/lsir_regs_sva.sv]
// port assertions for the line status and interrupt register group
`timescale 1ns/100ps
module lsir_regs_sva
    import lsir_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic irq,
    input wire lsir_term_t tx_term,
    input wire lsir_term_t rx_term
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    sequence rd_taken;
        ce && s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_taken;
        ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read not answered");
    AST_WR_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    AST_WR_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    AST_AR_REFUSE: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read ready wrong");
    AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    AST_TERM: assert property ($onehot(tx_term) && $onehot(rx_term))
        else $error("termination not one-hot");
    AST_RST_OUT: assert property ($fell(rst) |-> !irq && tx_term == 5'h01 && rx_term == 5'h10)
        else $error("bad reset outputs");
    // only a register write can lower the interrupt, events only raise it
    AST_IRQ_FALL: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("irq fell without a write");
endmodule
bind lsir_regs lsir_regs_sva u_sva (.clock, .rst, .ce, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .irq, .tx_term, .rx_term);

// [verification/tb.sv]
// self-checking bench for the line status and interrupt register group
`timescale 1ns/100ps
module tb;
    import lsir_pkg::*;
    localparam int SC = 40;
    logic clock = 0, rst = 1, awv = 0, wv = 0, arv = 0, dfp = 0, slp = 0;
    logic awr, wrd, bv, arr, rv, irq, txs, rxs;
    logic [7:0] aw = 0, ar = 0;
    logic [31:0] wd = 0, rdat, got;
    logic [1:0] bresp, rresp, rs;
    logic [4:0] gain = 0;
    logic [6:0] tsp = 0, rsp = 0;
    logic [15:0] cnt = 0;
    lsir_events_t ev = '0;
    lsir_term_t txt, rxt;
    int num_errors = 0, cmp_count = 0, m[64], pa = 0, pb = 0, a, b, k;
    lsir_regs #(.SECOND_CYCLES(SC)) dut (.clock, .rst, .ce(1'b1), .s_axi_awaddr(aw),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(1'b1), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
        .driver_fail_pin(dfp), .signal_loss_pin(slp), .equalizer_gain_in(gain),
        .tx_pointer_spacing(tsp), .rx_pointer_spacing(rsp), .excess_zero_count(cnt),
        .line_events(ev), .tx_term(txt), .rx_term(rxt), .tx_peak_measure_select(txs),
        .rx_peak_measure_select(rxs), .irq);
    initial forever #20 clock = ~clock;
    ////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // ready is sampled 1 ns after the edge, so it is the level the next edge sees
    task automatic xf(input bit w, input int i, input int d);
        logic ta, tw, tr, dn;
        aw <= 8'(i * 4);
        ar <= 8'(i * 4);
        wd <= d;
        awv <= w;
        wv <= w;
        arv <= !w;
        for (int n = 0; n < 60; n++)
        begin
            #1;
            dn = w ? bv : rv;
            rs = w ? bresp : rresp;
            got = rdat;
            ta = awv & awr;
            tw = wv & wrd;
            tr = arv & arr;
            @(posedge clock);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
            if (tr) arv <= 0;
            if (dn) return;
        end
        num_errors++;
        conclude;
    endtask
    task automatic wr(input int i, input int d);
        case (i)
            LSIR_IDX_TX_TEST, LSIR_IDX_RX_TEST: m[i] = d & LSIR_MASK_TEST;
            LSIR_IDX_CNT_CTRL: m[i] = d & LSIR_MASK_CNT_CTRL;
            LSIR_IDX_TERM: m[i] = d & LSIR_MASK_TERM;
            LSIR_IDX_EN_A, LSIR_IDX_EDGE: m[i] = d & LSIR_MASK_A;
            LSIR_IDX_EN_B: m[i] = d & LSIR_MASK_B;
            LSIR_IDX_PEND_A: pa &= ~d;
            LSIR_IDX_PEND_B: pb &= ~d;
            default: ;
        endcase
        xf(1, i, d);
    endtask
    task automatic rc(input int i, input int e);
        xf(0, i, 0);
        chk($sformatf("reg %0h", i), e, got);
    endtask
    // irq is registered: look 1 ns past the edge so the update of that edge has landed
    task automatic ci;
        #1;
        chk("irq", |(pa & m[LSIR_IDX_EN_A] | pb & m[LSIR_IDX_EN_B]), irq);
        @(posedge clock);
    endtask
    task automatic sn(input int e);
        rc(LSIR_IDX_CNT_HI, e >> 8);
        rc(LSIR_IDX_CNT_LO, e & 255);
    endtask
    function automatic logic [4:0] dc(logic [2:0] c);
        return c[2] ? 5'h10 : 5'h01 << c[1:0];
    endfunction
    ////////////////////////////////////////////////////////////////
    initial
    begin
        a = $urandom(32'hF4C1);
        m = '{default: 0};
        m[LSIR_IDX_TERM] = LSIR_RST_TERM;
        repeat (16) @(posedge clock);
        rst <= 0;
        @(posedge clock);
        for (k = LSIR_IDX_TERM; k <= LSIR_IDX_CNT_LO; k++)
            rc(k, m[k]);
        for (k = 0; k < 8; k++)
        begin
            a = $urandom & 8'hC7 | k << 3;
            wr(LSIR_IDX_TERM, a);
            rc(LSIR_IDX_TERM, m[LSIR_IDX_TERM]);
            chk("tx_term", dc(3'(k)), txt);
            chk("rx_term", dc(3'(a)), rxt);
        end
        for (k = LSIR_IDX_EN_A; k <= LSIR_IDX_EDGE; k++)
        begin
            wr(k, $urandom);
            rc(k, m[k]);
        end
        wr(LSIR_IDX_LIVE, 8'hFF);
        rc(LSIR_IDX_LIVE, 0);
        wr(0, 8'hFF);
        chk("bresp", 2, rs);
        rc(0, 0);
        chk("rresp", 2, rs);
        for (k = 0; k < 2; k++)
        begin
            wr(LSIR_IDX_EDGE, 5 * k);
            wr(LSIR_IDX_EN_A, 5 - k);
            dfp <= 1;
            slp <= 1;
            repeat (6) @(posedge clock);
            pa = 5;
            ci;
            rc(LSIR_IDX_LIVE, 5);
            wr(LSIR_IDX_PEND_A, 5);
            dfp <= 0;
            slp <= 0;
            repeat (6) @(posedge clock);
            pa = 5 * k;
            rc(LSIR_IDX_PEND_A, pa);
            ci;
            wr(LSIR_IDX_PEND_A, 5);
        end
        for (k = 0; k < 6; k++)
        begin
            ev <= lsir_events_t'(6'(1 << k));
            @(posedge clock);
            ev <= '0;
            pb |= 1 << (k + (k > 2));
            wr(LSIR_IDX_EN_B, $urandom);
            ci;
            rc(LSIR_IDX_PEND_B, pb);
        end
        wr(LSIR_IDX_PEND_B, $urandom);
        rc(LSIR_IDX_PEND_B, pb);
        ci;
        cnt <= 16'($urandom);
        gain <= 5'($urandom);
        wr(LSIR_IDX_CNT_CTRL, 0);
        a = cnt;
        wr(LSIR_IDX_CNT_CTRL, 1);
        cnt <= 16'($urandom);
        wr(LSIR_IDX_CNT_CTRL, 1);
        sn(a);
        wr(LSIR_IDX_CNT_CTRL, 3);
        repeat (2 * SC + 4) @(posedge clock);
        sn(cnt);
        rc(LSIR_IDX_GAIN, gain);
        a = $urandom & 127;
        b = $urandom & 127;
        tsp <= 7'(a);
        rsp <= 7'(a);
        // the measure register follows the spacing one edge later
        @(posedge clock);
        rc(LSIR_IDX_TX_JIT, a);
        rc(LSIR_IDX_RX_JIT, a);
        wr(LSIR_IDX_TX_TEST, 8'hFF);
        wr(LSIR_IDX_RX_TEST, 8'hFF);
        chk("peak_sel", 2'b11, {txs, rxs});
        rc(LSIR_IDX_TX_TEST, m[LSIR_IDX_TX_TEST]);
        xf(0, LSIR_IDX_TX_JIT, 0);
        xf(0, LSIR_IDX_RX_JIT, 0);
        tsp <= 7'(b);
        rsp <= 7'(b);
        repeat (3) @(posedge clock);
        tsp <= 7'(a);
        rsp <= 7'(a);
        a = a > b ? a - b : b - a;
        rc(LSIR_IDX_TX_JIT, a);
        rc(LSIR_IDX_RX_JIT, a);
        // spacing moves, so only a working clear brings the peak value back to zero
        tsp <= 7'(b);
        rsp <= 7'(b);
        wr(LSIR_IDX_TX_JIT, 1);
        wr(LSIR_IDX_RX_JIT, 1);
        rc(LSIR_IDX_TX_JIT, 0);
        rc(LSIR_IDX_RX_JIT, 0);
        conclude;
    end
endmodule
